/* shared/key_scan_port_cfg.svh */
// Constants of the key-scan port register block: offsets, bit positions,
// reset values and write masks. Included by the design only.
`ifndef KEY_SCAN_PORT_CFG_SVH
`define KEY_SCAN_PORT_CFG_SVH

// ****************************************
// Register offsets
// ****************************************
`define KSP_ADDR_W 3
`define KSP_OFF_SCAN 3'h0
`define KSP_OFF_INPUT 3'h1
`define KSP_OFF_CARRIER 3'h3
`define KSP_OFF_MODE 3'h4

// ****************************************
// Mode control fields
// ****************************************
`define KSP_MODE_SENSE_A_IN 0
`define KSP_MODE_SCAN_OUT 1
`define KSP_MODE_INDICATOR 2
`define KSP_MODE_SENSE_PD 4
`define KSP_MODE_ENTRY_PD 5
`define KSP_MODE_WMASK 8'h37
`define KSP_MODE_RESET 8'h26

// ****************************************
// Carrier and pointer control fields
// ****************************************
`define KSP_CAR_SEL_LO 0
`define KSP_CAR_SEL_HI 1
`define KSP_CAR_DISABLE 2
`define KSP_CAR_DIVIDE 3
`define KSP_CAR_PTR_LO 4
`define KSP_CAR_PTR_HI 5
`define KSP_CAR_WMASK 8'h3F
`define KSP_CAR_RESET 8'h03

// ****************************************
// Scan port and input register layout
// ****************************************
`define KSP_SCAN_RESET 8'hFF
`define KSP_IN_FIXED_ONES 2'h3
`define KSP_IN_SENSE_A 2
`define KSP_IN_INDICATOR 3
`define KSP_IN_ENTRY_LO 4
`define KSP_INDICATOR_RESET 1'h1

`endif

/* shared/key_scan_port_pkg.sv */
// Types shared by the key-scan port register block and its bench.
// Assumes key_scan_port_cfg.svh is on the include path.
package key_scan_port_pkg;

  // ****************************************
  // Register access request
  // ****************************************
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  // ****************************************
  // Key-scan pin drive
  // ****************************************
  typedef struct packed {
    logic [7:0] level;
    logic [7:0] enable;
  } scan_drive_t;

  // ****************************************
  // Carrier and pointer settings
  // ****************************************
  typedef struct packed {
    logic [1:0] carrier_select;
    logic carrier_disable;
    logic timer_divide_select;
    logic [1:0] table_pointer_hi;
  } carrier_cfg_t;

endpackage

/* hdl/key_scan_port_registers.sv */
// Port registers of a small key-scan controller: scan port, key entry,
// two sense pins and two control registers.
// Assumes a register port on core_clk and pins from outside that domain.
//
// Contract
// - Scan port eight bits, bit0 lowest pin
// - Mode bit 1 sets whole scan direction
// - Scan read: pins in input, latch output
// - Scan write always loads the latch
// - Reset: scan output mode, latch all ones
// - Scan pull-downs only in input mode
// - Key entry four read-only bits 4-7
// - Mode bit 5 enables entry pull-downs
// - Entry pull-downs enabled after reset
// - Input register low bits read one
// - Writes to read-only input bits ignored
// - Sense A at bit 2, mode bit 0
// - Sense A off: hi-Z, gated, reads one
// - Reset puts sense A off
// - Mode bit 4 sense pull-downs, input only
// - Indicator bit reads pin in both modes
// - Mode register bit encodings as documented
// - Mode register resets to 0010 0110
// - Reset: indicator pin outputs high
`timescale 1ns/100ps
`include "key_scan_port_cfg.svh"

module key_scan_port_registers (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire key_scan_port_pkg::reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  input wire logic [7:0] key_scan_io_in,
  output key_scan_port_pkg::scan_drive_t key_scan_io_drive,
  output logic key_scan_pulldown_en,
  input wire logic [3:0] key_entry_input,
  output logic key_entry_pulldown_en,
  input wire logic sense_pin_a,
  output logic sense_a_input_en,
  output logic sense_a_pulldown_en,
  input wire logic sense_indicator_pin_in,
  output logic sense_indicator_pin_out,
  output logic sense_indicator_pin_oe,
  output logic sense_indicator_pulldown_en,
  input wire logic indicator_level,
  output key_scan_port_pkg::carrier_cfg_t carrier_cfg
);
  import key_scan_port_pkg::*;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  localparam int PIN_N = 14;

  logic [PIN_N-1:0] pin_raw;
  logic [PIN_N-1:0] pin_meta_q;
  logic [PIN_N-1:0] pin_sync_q;

  assign pin_raw = {sense_indicator_pin_in, sense_pin_a, key_entry_input, key_scan_io_in};

  genvar gi;
  generate
    for (gi = 0; gi < PIN_N; gi++) begin : g_sync
      // First stage feeds only the second
      always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
          pin_meta_q[gi] <= 1'h0;
          pin_sync_q[gi] <= 1'h0;
        end else begin
          pin_meta_q[gi] <= pin_raw[gi];
          pin_sync_q[gi] <= pin_meta_q[gi];
        end
      end
    end
  endgenerate

  logic [7:0] scan_pins;
  logic [3:0] entry_pins;
  logic sense_a_sync;
  logic indicator_sync;

  assign scan_pins = pin_sync_q[7:0];
  assign entry_pins = pin_sync_q[11:8];
  assign sense_a_sync = pin_sync_q[12];
  assign indicator_sync = pin_sync_q[13];

  // ****************************************
  // Write decode
  // ****************************************
  logic wr_scan;
  logic wr_carrier;
  logic wr_mode;

  assign wr_scan = reg_req.wr && (reg_req.addr == `KSP_OFF_SCAN);
  assign wr_carrier = reg_req.wr && (reg_req.addr == `KSP_OFF_CARRIER);
  assign wr_mode = reg_req.wr && (reg_req.addr == `KSP_OFF_MODE);
  // Input register has no write path at all

  // ****************************************
  // Scan output latch
  // ****************************************
  logic [7:0] scan_latch_q;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      scan_latch_q <= `KSP_SCAN_RESET;
    end else if (wr_scan) begin
      scan_latch_q <= reg_req.wdata;
    end
  end

  // ****************************************
  // Mode control register
  // ****************************************
  logic [7:0] mode_q;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_q <= `KSP_MODE_RESET;
    end else if (wr_mode) begin
      mode_q <= reg_req.wdata & `KSP_MODE_WMASK;
    end
  end

  logic scan_out_mode;
  logic sense_a_in_mode;
  logic indicator_mode;

  assign scan_out_mode = mode_q[`KSP_MODE_SCAN_OUT];
  assign sense_a_in_mode = mode_q[`KSP_MODE_SENSE_A_IN];
  assign indicator_mode = mode_q[`KSP_MODE_INDICATOR];

  // ****************************************
  // Carrier and pointer control register
  // ****************************************
  logic [7:0] carrier_q;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      carrier_q <= `KSP_CAR_RESET;
    end else if (wr_carrier) begin
      carrier_q <= reg_req.wdata & `KSP_CAR_WMASK;
    end
  end

  assign carrier_cfg.carrier_select = {carrier_q[`KSP_CAR_SEL_HI], carrier_q[`KSP_CAR_SEL_LO]};
  assign carrier_cfg.carrier_disable = carrier_q[`KSP_CAR_DISABLE];
  assign carrier_cfg.timer_divide_select = carrier_q[`KSP_CAR_DIVIDE];
  assign carrier_cfg.table_pointer_hi = {carrier_q[`KSP_CAR_PTR_HI], carrier_q[`KSP_CAR_PTR_LO]};

  // ****************************************
  // Pin drives and pull-downs
  // ****************************************
  assign key_scan_io_drive.level = scan_latch_q;
  assign key_scan_io_drive.enable = {8{scan_out_mode}};
  assign key_scan_pulldown_en = !scan_out_mode;
  assign key_entry_pulldown_en = mode_q[`KSP_MODE_ENTRY_PD];
  // Off mode also gates the input buffer so no through current flows
  assign sense_a_input_en = sense_a_in_mode;
  assign sense_a_pulldown_en = sense_a_in_mode && mode_q[`KSP_MODE_SENSE_PD];
  assign sense_indicator_pulldown_en = !indicator_mode && mode_q[`KSP_MODE_SENSE_PD];

  // Indicator level comes from the timer; registered to keep the pin glitch-free
  logic indicator_out_q;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      indicator_out_q <= `KSP_INDICATOR_RESET;
    end else begin
      indicator_out_q <= indicator_level;
    end
  end

  assign sense_indicator_pin_out = indicator_out_q;
  assign sense_indicator_pin_oe = indicator_mode;

  // ****************************************
  // Read path
  // ****************************************
  logic [7:0] input_reg_view;
  logic [7:0] read_mux;

  always_comb begin
    input_reg_view = 8'h00;
    input_reg_view[1:0] = `KSP_IN_FIXED_ONES;
    input_reg_view[`KSP_IN_SENSE_A] = sense_a_in_mode ? sense_a_sync : 1'h1;
    input_reg_view[`KSP_IN_INDICATOR] = indicator_sync;
    input_reg_view[7:`KSP_IN_ENTRY_LO] = entry_pins;
  end

  always_comb begin
    case (reg_req.addr)
      `KSP_OFF_SCAN: read_mux = scan_out_mode ? scan_latch_q : scan_pins;
      `KSP_OFF_INPUT: read_mux = input_reg_view;
      `KSP_OFF_CARRIER: read_mux = carrier_q;
      `KSP_OFF_MODE: read_mux = mode_q;
      default: read_mux = 8'h00;
    endcase
  end

  // Data stand only in the cycle after the strobe
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_req.rd) begin
      reg_rdata <= read_mux;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule // key_scan_port_registers

/* testbench/key_scan_port_monitor.sv */
// Checker of the key-scan port registers.
// Assumes it is bound to the design top module.
`timescale 1ns/100ps
module key_scan_port_monitor (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire key_scan_port_pkg::reg_req_t reg_req,
  input wire logic [7:0] reg_rdata,
  input wire key_scan_port_pkg::scan_drive_t key_scan_io_drive,
  input wire logic key_scan_pulldown_en,
  input wire logic key_entry_pulldown_en,
  input wire logic sense_a_input_en,
  input wire logic sense_a_pulldown_en,
  input wire logic sense_indicator_pin_out,
  input wire logic sense_indicator_pin_oe,
  input wire logic sense_indicator_pulldown_en,
  input wire logic indicator_level
);
  import key_scan_port_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  a_scan_dir_all: assert property (key_scan_io_drive.enable == {8{!key_scan_pulldown_en}})
    else $error("scan direction split");
  a_scan_latch_wr: assert property (reg_req.wr && reg_req.addr == 3'h0 |=>
    key_scan_io_drive.level == $past(reg_req.wdata)) else $error("latch not loaded");
  a_scan_read_src: assert property (reg_req.rd && reg_req.addr == 3'h0 &&
    key_scan_io_drive.enable[0] |=> reg_rdata == key_scan_io_drive.level) else $error("scan read");
  a_rdata_idle: assert property (!reg_req.rd |=> reg_rdata == 8'h00)
    else $error("read data not idle");
  a_input_fixed_ones: assert property (reg_req.rd && reg_req.addr == 3'h1 |=>
    reg_rdata[1:0] == 2'h3) else $error("low bits not one");
  a_sense_off_one: assert property (reg_req.rd && reg_req.addr == 3'h1 &&
    !sense_a_input_en |=> reg_rdata[2]) else $error("off sense not one");
  a_mode_fields: assert property (reg_req.wr && reg_req.addr == 3'h4 |=>
    {key_entry_pulldown_en, sense_indicator_pin_oe, key_scan_io_drive.enable[0],
    sense_a_input_en} == {$past(reg_req.wdata[5]), $past(reg_req.wdata[2]),
    $past(reg_req.wdata[1]), $past(reg_req.wdata[0])}) else $error("mode fields");
  a_pulldown_gate: assert property (!(sense_a_pulldown_en && !sense_a_input_en) &&
    !(sense_indicator_pulldown_en && sense_indicator_pin_oe)) else $error("pull-down");
  a_indicator_out: assert property ($past(reset_n) |->
    sense_indicator_pin_out == $past(indicator_level)) else $error("indicator level");
endmodule // key_scan_port_monitor
bind key_scan_port_registers key_scan_port_monitor mon (.core_clk, .reset_n, .reg_req,
  .reg_rdata, .key_scan_io_drive, .key_scan_pulldown_en, .key_entry_pulldown_en,
  .sense_a_input_en, .sense_a_pulldown_en, .sense_indicator_pin_out,
  .sense_indicator_pin_oe, .sense_indicator_pulldown_en, .indicator_level);

/* testbench/key_matrix_model.sv */
// Model of the key matrix and sense pins outside the port block.
// Assumes the bench picks the levels the outside world presents.
`timescale 1ns/100ps
module key_matrix_model (
  input wire logic core_clk,
  input wire key_scan_port_pkg::scan_drive_t drive,
  input wire logic ind_oe,
  input wire logic ind_out,
  input wire logic sense_a_en,
  input wire logic [7:0] want_scan,
  input wire logic [3:0] want_entry,
  input wire logic want_a,
  input wire logic want_ind,
  output logic [7:0] scan_pins,
  output logic [3:0] entry_pins,
  output logic sense_a,
  output logic ind_pin
);
  logic flip_q = 1'b0;
  always_ff @(posedge core_clk) begin
    flip_q <= !flip_q;
  end
  // Driven pins show the latch, released ones the keys
  assign scan_pins = (drive.enable & drive.level) | (~drive.enable & want_scan);
  assign ind_pin = ind_oe ? ind_out : want_ind;
  // Gated pin toggles so a stale level cannot pass
  assign sense_a = sense_a_en ? want_a : flip_q;
  assign entry_pins = want_entry;
endmodule // key_matrix_model

/* testbench/key_scan_port_registers_test.sv */
// Self-checking bench of the key-scan port registers.
// Assumes design, checker and pin model are compiled first.
`timescale 1ns/100ps
module key_scan_port_registers_test;
  import key_scan_port_pkg::*;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  reg_req_t reg_req = '0;
  logic [7:0] reg_rdata, scan_pins, m, v, want_scan = 8'h00;
  logic [3:0] entry_pins, want_entry = 4'h6;
  logic sense_a, ind_pin, want_a = 1'b0, want_ind = 1'b0, indicator_level = 1'b1;
  logic scan_pd, entry_pd, a_en, a_pd, ind_out, ind_oe, ind_pd;
  scan_drive_t drive;
  carrier_cfg_t carrier_cfg;
  integer seed = 76, n_fail = 0, n_compared = 0, cycles = 0, i, r;
  initial begin
    forever #20 core_clk = !core_clk;
  end
  key_scan_port_registers dut (.core_clk, .reset_n, .reg_req, .reg_rdata,
    .key_scan_io_in(scan_pins), .key_scan_io_drive(drive), .key_scan_pulldown_en(scan_pd),
    .key_entry_input(entry_pins), .key_entry_pulldown_en(entry_pd), .sense_pin_a(sense_a),
    .sense_a_input_en(a_en), .sense_a_pulldown_en(a_pd), .sense_indicator_pin_in(ind_pin),
    .sense_indicator_pin_out(ind_out), .sense_indicator_pin_oe(ind_oe),
    .sense_indicator_pulldown_en(ind_pd), .indicator_level, .carrier_cfg);
  key_matrix_model pins (.core_clk, .drive, .ind_oe, .ind_out, .sense_a_en(a_en), .want_scan,
    .want_entry, .want_a, .want_ind, .scan_pins, .entry_pins, .sense_a, .ind_pin);
  // ********
  // Tasks
  // ********
  function automatic logic [7:0] exp_in(input logic [7:0] md);
    return {want_entry, md[2] ? indicator_level : want_ind, md[0] ? want_a : 1'b1, 2'h3};
  endfunction
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    reg_req.wr <= 1'b0;
    #1;
  endtask
  task rchk(input logic [2:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    reg_req.rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask
  task report_and_stop;
    $display("compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 2000) begin
      n_fail++;
      report_and_stop;
    end
  end
  // ********
  // Sequence
  // ********
  initial begin
    repeat (5) @(posedge core_clk);
    reset_n <= 1'b1;
    #1 chk(drive.level, 8'hFF);
    chk({2'h0, carrier_cfg}, 8'h30);
    chk(drive.enable, 8'hFF);
    chk({1'b0, scan_pd, entry_pd, a_en, a_pd, ind_oe, ind_out, ind_pd}, 8'h26);
    rchk(3'h4, 8'h26);
    rchk(3'h1, exp_in(8'h26));
    rchk(3'h3, 8'h03);
    rchk(3'h0, 8'hFF);
    $display("reset test done");
    for (i = 0; i < 12; i++) begin
      @(posedge core_clk);
      r = $random(seed);
      m = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : r[7:0];
      v = r[15:8];
      want_scan <= r[23:16];
      want_entry <= r[27:24];
      {want_a, want_ind, indicator_level} <= r[30:28];
      wr(3'h4, m);
      chk(drive.enable, {8{m[1]}});
      chk({2'h0, scan_pd, entry_pd, a_en, a_pd, ind_oe, ind_pd},
        {2'h0, !m[1], m[5], m[0], m[0] & m[4], m[2], !m[2] & m[4]});
      wr(3'h0, v);
      chk(drive.level, v);
      wr(3'h1, ~v);
      wr(3'h5, v);
      rchk(3'h0, m[1] ? v : want_scan);
      rchk(3'h1, exp_in(m));
      rchk(3'h5, 8'h00);
      rchk(3'h4, m & 8'h37);
      wr(3'h3, v);
      rchk(3'h3, v & 8'h3F);
      chk({2'h0, carrier_cfg}, {2'h0, v[1:0], v[2], v[3], v[5:4]});
    end
    $display("random test done");
    // Second reset in mid-run must restore every register
    @(posedge core_clk);
    want_entry <= 4'h6;
    reset_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    #1 chk(drive.level, 8'hFF);
    chk(drive.enable, 8'hFF);
    chk({2'h0, carrier_cfg}, 8'h30);
    rchk(3'h4, 8'h26);
    rchk(3'h1, exp_in(8'h26));
    $display("reset again test done");
    report_and_stop;
  end
endmodule // key_scan_port_registers_test
